// *** rtl/rseq_top.sv ***
// enable sequencing for three auxiliary regulators, switch routing and step-down-six pin voltage
`timescale 1ns/1ns
`default_nettype none
`include "rseq_defines.svh"
module rseq_top import rseq_pkg::*; #(
  parameter int unsigned MS_CYCLES = `RSEQ_MS_CYCLES
) (
  input  wire logic          clk_in,
  input  wire logic          srst_in,
  input  wire logic          ce_in,
  input  wire rseq_reg_req_t reg_req_in,
  output logic [7:0]         reg_rdata_out,
  output logic               reg_rvalid_out,
  input  wire logic [5:0]    control_input_in,
  input  wire logic          sleep_input_in,
  input  wire rseq_pg_t      power_good_flag_in,
  input  wire logic          aux_two_logic_en_in,
  input  wire logic          aux_one_logic_en_in,
  input  wire logic          switch_b_one_logic_en_in,
  input  wire logic          switch_b_two_logic_en_in,
  input  wire logic          step_down_six_step_25mv_in,
  output logic               aux_regulator_two_en_out,
  output logic               aux_regulator_three_en_out,
  output logic               aux_regulator_one_en_out,
  output logic               load_switch_b_two_en_out,
  output logic               stepdown_six_pin_vsel_out,
  output logic [11:0]        stepdown_six_target_mv_out
);
  // ----------------------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------------------
  logic [7:0] regtwo_q, regtwo_d, mask_main_q, mask_main_d;
  logic [7:0] pinsel_q, pinsel_d, dly3_q, dly3_d;
  logic [7:0] rdata_d;

  // reserved bits 6:5 of the pin-select register are not stored and read as zero
  always_comb begin
    regtwo_d    = regtwo_q;
    mask_main_d = mask_main_q;
    pinsel_d    = pinsel_q;
    dly3_d      = dly3_q;
    if (reg_req_in.wr) begin
      case (reg_req_in.addr)
        `RSEQ_OFS_REGTWO_DLY:   regtwo_d    = reg_req_in.wdata;
        `RSEQ_OFS_PG_MASK_MAIN: mask_main_d = reg_req_in.wdata;
        `RSEQ_OFS_PIN_SELECT:   pinsel_d    = reg_req_in.wdata & 8'h9f;
        `RSEQ_OFS_DLY_SWITCH:   dly3_d      = reg_req_in.wdata;
        default:                ;
      endcase
    end
    case (reg_req_in.addr)
      `RSEQ_OFS_REGTWO_DLY:   rdata_d = regtwo_q;
      `RSEQ_OFS_PG_MASK_MAIN: rdata_d = mask_main_q;
      `RSEQ_OFS_PIN_SELECT:   rdata_d = pinsel_q;
      `RSEQ_OFS_DLY_SWITCH:   rdata_d = dly3_q;
      default:                rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      regtwo_q       <= `RSEQ_REG_RESET;
      mask_main_q    <= `RSEQ_REG_RESET;
      pinsel_q       <= `RSEQ_REG_RESET;
      dly3_q         <= `RSEQ_REG_RESET;
      reg_rdata_out  <= 8'h00;
      reg_rvalid_out <= 1'b0;
    end else if (ce_in) begin
      regtwo_q       <= regtwo_d;
      mask_main_q    <= mask_main_d;
      pinsel_q       <= pinsel_d;
      dly3_q         <= dly3_d;
      reg_rdata_out  <= reg_req_in.rd ? rdata_d : reg_rdata_out;
      reg_rvalid_out <= reg_req_in.rd;
    end
  end

  // ----------------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------------
  // pins are asynchronous; only the second stage is read anywhere
  logic [16:0] sync1_q, sync2_q;
  logic [5:0]  ctl_s;
  logic        sleep_s;
  logic [9:0]  pg_s;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      sync1_q <= 17'h00000;
      sync2_q <= 17'h00000;
    end else if (ce_in) begin
      sync1_q <= {control_input_in, sleep_input_in, power_good_flag_in};
      sync2_q <= sync1_q;
    end
  end
  assign ctl_s   = sync2_q[16:11];
  assign sleep_s = sync2_q[10];
  assign pg_s    = sync2_q[9:0];

  // ----------------------------------------------------------------------------
  // source mux, power-good gating
  // ----------------------------------------------------------------------------
  logic [2:0]    pin_sel;
  logic [9:0]    mask_all;
  logic          pg_ok;
  logic [1:0]    dly_raw, dly_out;
  rseq_dly_cfg_t dly_cfg [2];

  assign pin_sel  = pinsel_q[`RSEQ_PINSEL_LSB +: 3];
  assign mask_all = {pinsel_q[`RSEQ_MASK_CMB_BIT],
                     pinsel_q[`RSEQ_MASK_LOAD_SWITCH_B_ONE_BIT], mask_main_q};
  assign pg_ok    = &(pg_s | mask_all);

  // control-input mux for regulator three
  always_comb begin
    case (pin_sel)
      3'h0:    dly_raw[1] = ctl_s[0];
      3'h1:    dly_raw[1] = ctl_s[1];
      3'h2:    dly_raw[1] = ctl_s[4];
      3'h3:    dly_raw[1] = ctl_s[3];
      3'h4:    dly_raw[1] = ctl_s[2];
      3'h5:    dly_raw[1] = ctl_s[2] & ctl_s[3];
      3'h6:    dly_raw[1] = ctl_s[5];
      default: dly_raw[1] = 1'b1;
    endcase
    dly_raw[0] = aux_two_logic_en_in;
  end

  assign dly_cfg[0] = '{rise: regtwo_q[`RSEQ_RISE_LSB +: 3], fall: regtwo_q[`RSEQ_FALL_LSB +: 3]};
  assign dly_cfg[1] = '{rise: dly3_q[`RSEQ_RISE_LSB +: 3], fall: dly3_q[`RSEQ_FALL_LSB +: 3]};

  // one edge filter per regulator (0: aux two, 1: aux three)
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_dly
      rseq_edge_delay #(.MS_CYCLES(MS_CYCLES)) rseq_edge_delay_i (
        .clk_in    (clk_in),
        .srst_in   (srst_in),
        .ce_in     (ce_in),
        .level_in  (dly_raw[gi]),
        .cfg_in    (dly_cfg[gi]),
        .level_out (dly_out[gi])
      );
    end
  endgenerate
  assign aux_regulator_two_en_out = dly_out[0];

  // ----------------------------------------------------------------------------
  // shutdown off time, switch routing, step-down six
  // ----------------------------------------------------------------------------
  logic        off_busy_q, off_busy_d, one_gated_q, one_gated_d;
  logic [31:0] off_cnt_q, off_cnt_d, off_cycles;
  logic        b_two_src, combine, swap;
  logic        three_en_d, one_en_d, b_two_en_d, vsel_d;
  logic [11:0] mv_d;

  assign combine = dly3_q[`RSEQ_COMBINE_BIT];
  assign swap    = dly3_q[`RSEQ_SWAP_BIT];

  always_comb begin
    case (regtwo_q[`RSEQ_OFFTIME_LSB +: 2])
      2'h0:    off_cycles = 32'(`RSEQ_OFF0_MS * MS_CYCLES);
      2'h1:    off_cycles = 32'(`RSEQ_OFF1_MS * MS_CYCLES);
      2'h2:    off_cycles = 32'(`RSEQ_OFF2_MS * MS_CYCLES);
      default: off_cycles = 32'(`RSEQ_OFF3_MS * MS_CYCLES);
    endcase
  end

  // off time starts when regulator one's logic drops; re-enable waits it out
  always_comb begin
    off_busy_d = off_busy_q;
    off_cnt_d  = off_cnt_q;
    if (off_busy_q) begin
      if (off_cnt_q == 32'h0) off_busy_d = 1'b0;
      else off_cnt_d = off_cnt_q - 32'h1;
    end else if (one_gated_q && !aux_one_logic_en_in) begin
      off_busy_d = 1'b1;
      off_cnt_d  = off_cycles - 32'h1;
    end
    one_gated_d = aux_one_logic_en_in && !off_busy_d;
  end

  always_comb begin
    three_en_d = dly_out[1] & pg_ok;
    b_two_src  = combine ? switch_b_one_logic_en_in : switch_b_two_logic_en_in;
    one_en_d   = swap ? b_two_src : one_gated_d;
    b_two_en_d = swap ? one_gated_d : b_two_src;
    vsel_d     = pinsel_q[`RSEQ_VSEL_OPT_BIT] & ctl_s[1] & !sleep_s;
    mv_d       = step_down_six_step_25mv_in ? `RSEQ_SD6_MV_COARSE : `RSEQ_SD6_MV_FINE;
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      off_busy_q                 <= 1'b0;
      off_cnt_q                  <= 32'h0;
      one_gated_q                <= 1'b0;
      aux_regulator_three_en_out <= 1'b0;
      aux_regulator_one_en_out   <= 1'b0;
      load_switch_b_two_en_out   <= 1'b0;
      stepdown_six_pin_vsel_out  <= 1'b0;
      stepdown_six_target_mv_out <= `RSEQ_SD6_MV_FINE;
    end else if (ce_in) begin
      off_busy_q                 <= off_busy_d;
      off_cnt_q                  <= off_cnt_d;
      one_gated_q                <= one_gated_d;
      aux_regulator_three_en_out <= three_en_d;
      aux_regulator_one_en_out   <= one_en_d;
      load_switch_b_two_en_out   <= b_two_en_d;
      stepdown_six_pin_vsel_out  <= vsel_d;
      stepdown_six_target_mv_out <= mv_d;
    end
  end

  // ----------------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------------
  three_gate_a: assert property (@(posedge clk_in) disable iff (srst_in)
    ce_in |=> aux_regulator_three_en_out == $past(dly_out[1] & pg_ok))
    else $error("regulator three enable not source and power-good");
  pg_block_a: assert property (@(posedge clk_in) disable iff (srst_in)
    ce_in && !pg_ok |=> !aux_regulator_three_en_out)
    else $error("enable rose with an unmasked rail not good");
  mask_all_a: assert property (@(posedge clk_in) disable iff (srst_in)
    ce_in && (&mask_all) && dly_out[1] |=> aux_regulator_three_en_out)
    else $error("fully masked enable blocked");
  force_one_a: assert property (@(posedge clk_in) disable iff (srst_in)
    pin_sel == `RSEQ_PINSEL_FORCE |-> dly_raw[1])
    else $error("forced select did not insert a one");
  sleep_wins_a: assert property (@(posedge clk_in) disable iff (srst_in)
    ce_in && sleep_s |=> !stepdown_six_pin_vsel_out)
    else $error("pin voltage active during sleep");
  opt_off_a: assert property (@(posedge clk_in) disable iff (srst_in)
    ce_in && !pinsel_q[`RSEQ_VSEL_OPT_BIT] |=> !stepdown_six_pin_vsel_out)
    else $error("pin voltage active with option clear");
  opt_on_a: assert property (@(posedge clk_in) disable iff (srst_in)
    ce_in && pinsel_q[`RSEQ_VSEL_OPT_BIT] && ctl_s[1] && !sleep_s
    |=> stepdown_six_pin_vsel_out)
    else $error("pin voltage not applied");
  swap_route_a: assert property (@(posedge clk_in) disable iff (srst_in)
    ce_in && swap |=> aux_regulator_one_en_out == $past(b_two_src))
    else $error("swap did not route switch logic to regulator one");
  combine_a: assert property (@(posedge clk_in) disable iff (srst_in)
    ce_in && combine && !swap |=> load_switch_b_two_en_out == $past(switch_b_one_logic_en_in))
    else $error("combined switch enable not followed");
  off_hold_a: assert property (@(posedge clk_in) disable iff (srst_in)
    ce_in && off_busy_q && off_cnt_q != 32'h0 |=> !one_gated_q)
    else $error("regulator one re-enabled inside off time");
endmodule
`default_nettype wire

// *** shared/rseq_defines.svh ***
// register offsets, field positions, reset values and timing counts of the rail sequencer
`ifndef RSEQ_DEFINES_SVH
`define RSEQ_DEFINES_SVH
// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define RSEQ_OFS_REGTWO_DLY   8'h1e
`define RSEQ_OFS_PG_MASK_MAIN 8'h1f
`define RSEQ_OFS_PIN_SELECT   8'h20
`define RSEQ_OFS_DLY_SWITCH   8'h21
`define RSEQ_REG_RESET        8'h00
// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define RSEQ_OFFTIME_LSB      6
`define RSEQ_FALL_LSB         3
`define RSEQ_RISE_LSB         0
`define RSEQ_VSEL_OPT_BIT     7
`define RSEQ_PINSEL_LSB       2
`define RSEQ_MASK_CMB_BIT     1
`define RSEQ_MASK_LOAD_SWITCH_B_ONE_BIT    0
`define RSEQ_COMBINE_BIT      7
`define RSEQ_SWAP_BIT         6
`define RSEQ_PINSEL_FORCE     3'h7
// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define RSEQ_CLK_PERIOD_NS    8
`define RSEQ_NS_PER_MS        1000000
`define RSEQ_MS_CYCLES        (`RSEQ_NS_PER_MS / `RSEQ_CLK_PERIOD_NS)
`define RSEQ_DLY1_MS          2
`define RSEQ_DLY2_MS          4
`define RSEQ_DLY3_MS          8
`define RSEQ_DLY4_MS          16
`define RSEQ_DLY5_MS          24
`define RSEQ_DLY6_MS          32
`define RSEQ_DLY7_MS          64
`define RSEQ_OFF0_MS          1
`define RSEQ_OFF1_MS          5
`define RSEQ_OFF2_MS          10
`define RSEQ_OFF3_MS          100
`define RSEQ_SD6_MV_FINE      12'd1200
`define RSEQ_SD6_MV_COARSE    12'd2400
`endif

// *** shared/rseq_pkg.sv ***
// types shared by the rail sequencer modules
`default_nettype none
package rseq_pkg;
  // ----------------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rseq_reg_req_t;

  // power-good flags, msb first; low eight bits line up with the main mask register
  typedef struct packed {
    logic combined_rail;
    logic switch_b_one;
    logic aux_two;
    logic switch_a_one;
    logic step_down_six;
    logic step_down_five;
    logic step_down_four;
    logic step_down_three;
    logic step_down_two;
    logic step_down_one;
  } rseq_pg_t;

  typedef struct packed {
    logic [2:0] rise;
    logic [2:0] fall;
  } rseq_dly_cfg_t;

  typedef enum logic [3:0] {
    RSEQ_ST_LOW  = 4'b0001,
    RSEQ_ST_RISE = 4'b0010,
    RSEQ_ST_HIGH = 4'b0100,
    RSEQ_ST_FALL = 4'b1000
  } rseq_dly_state_t;
endpackage
`default_nettype wire

// *** rtl/rseq_edge_delay.sv ***
// rising and falling edge delay filter for one enable signal
`timescale 1ns/1ns
`default_nettype none
`include "rseq_defines.svh"
module rseq_edge_delay import rseq_pkg::*; #(
  parameter int unsigned MS_CYCLES = `RSEQ_MS_CYCLES
) (
  input  wire logic          clk_in,
  input  wire logic          srst_in,
  input  wire logic          ce_in,
  input  wire logic          level_in,
  input  wire rseq_dly_cfg_t cfg_in,
  output logic               level_out
);
  // ----------------------------------------------------------------------------
  // delay code to cycles
  // ----------------------------------------------------------------------------
  // nominal value exactly; well inside the ten percent the rail allows
  function automatic logic [31:0] dly_cycles(input logic [2:0] code);
    logic [31:0] ms;
    case (code)
      3'h1:    ms = 32'(`RSEQ_DLY1_MS);
      3'h2:    ms = 32'(`RSEQ_DLY2_MS);
      3'h3:    ms = 32'(`RSEQ_DLY3_MS);
      3'h4:    ms = 32'(`RSEQ_DLY4_MS);
      3'h5:    ms = 32'(`RSEQ_DLY5_MS);
      3'h6:    ms = 32'(`RSEQ_DLY6_MS);
      3'h7:    ms = 32'(`RSEQ_DLY7_MS);
      default: ms = 32'h0;
    endcase
    return 32'(ms * MS_CYCLES);
  endfunction

  rseq_dly_state_t st_q, st_d;
  logic [31:0]     cnt_q, cnt_d;
  logic            out_d;

  // ----------------------------------------------------------------------------
  // state machine
  // ----------------------------------------------------------------------------
  // a reversed edge during a wait cancels it, so the next edge restarts the count
  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q;
    case (st_q)
      RSEQ_ST_LOW: begin
        if (level_in) begin
          if (cfg_in.rise == 3'h0) st_d = RSEQ_ST_HIGH;
          else begin
            st_d  = RSEQ_ST_RISE;
            cnt_d = dly_cycles(cfg_in.rise) - 32'h1;
          end
        end
      end
      RSEQ_ST_RISE: begin
        if (!level_in) st_d = RSEQ_ST_LOW;
        else if (cnt_q == 32'h0) st_d = RSEQ_ST_HIGH;
        else cnt_d = cnt_q - 32'h1;
      end
      RSEQ_ST_HIGH: begin
        if (!level_in) begin
          if (cfg_in.fall == 3'h0) st_d = RSEQ_ST_LOW;
          else begin
            st_d  = RSEQ_ST_FALL;
            cnt_d = dly_cycles(cfg_in.fall) - 32'h1;
          end
        end
      end
      RSEQ_ST_FALL: begin
        if (level_in) st_d = RSEQ_ST_HIGH;
        else if (cnt_q == 32'h0) st_d = RSEQ_ST_LOW;
        else cnt_d = cnt_q - 32'h1;
      end
      default: st_d = RSEQ_ST_LOW;
    endcase
    out_d = (st_d == RSEQ_ST_HIGH) || (st_d == RSEQ_ST_FALL);
  end

  // registers, frozen while the clock enable is low
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      st_q      <= RSEQ_ST_LOW;
      cnt_q     <= 32'h0;
      level_out <= 1'b0;
    end else if (ce_in) begin
      st_q      <= st_d;
      cnt_q     <= cnt_d;
      level_out <= out_d;
    end
  end

  // ----------------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------------
  rise_nodelay_a: assert property (@(posedge clk_in) disable iff (srst_in)
    ce_in && st_q == RSEQ_ST_LOW && level_in && cfg_in.rise == 3'h0 |=> level_out)
    else $error("undelayed rise did not pass");
  rise_wait_a: assert property (@(posedge clk_in) disable iff (srst_in)
    ce_in && st_q == RSEQ_ST_LOW && level_in && cfg_in.rise != 3'h0 |=> !level_out)
    else $error("delayed rise passed at once");
  fall_hold_a: assert property (@(posedge clk_in) disable iff (srst_in)
    ce_in && st_q == RSEQ_ST_HIGH && !level_in && cfg_in.fall != 3'h0 |=> level_out)
    else $error("delayed fall dropped at once");
endmodule
`default_nettype wire

// *** testbench/rseq_pin_model.sv ***
// pin-side partner: control inputs, sleep pin and power-good flags of the other rails
`timescale 1ns/1ns
`default_nettype none
module rseq_pin_model import rseq_pkg::*; (
  input  wire logic     clk_in,
  input  wire logic [5:0] ctl_set_in,
  input  wire logic     sleep_set_in,
  input  wire rseq_pg_t pg_set_in,
  output logic [5:0]    control_input_out,
  output logic          sleep_input_out,
  output rseq_pg_t      power_good_flag_out
);
  // ----------------------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------------------
  // pins move just after an edge, like board logic clocked elsewhere
  always_ff @(posedge clk_in) begin
    control_input_out   <= ctl_set_in;
    sleep_input_out     <= sleep_set_in;
    power_good_flag_out <= pg_set_in;
  end
endmodule
`default_nettype wire

// *** testbench/rseq_top_tb.sv ***
// self-checking bench for the rail sequencer top
`timescale 1ns/1ns
`default_nettype none
`include "rseq_defines.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; \
  $display("mismatch at %0t: got %0h want %0h", $time, a, b); end end
module rseq_top_tb import rseq_pkg::*;;
  localparam int MS = 4; // short millisecond keeps the 100 ms off time at 400 cycles
  logic clk_in, srst_in, rvalid, s25, a1, a2, b1, b2, sleep_input, sleep_set;
  logic en1, en2, en3, enb2, vsel, ce;
  logic [7:0] rdata;
  logic [5:0] ctl, ctl_set;
  logic [11:0] mv;
  rseq_reg_req_t req;
  rseq_pg_t pg, pg_set;
  int num_errors, checked, n, base;
  int ms_tab [8] = '{0, 2, 4, 8, 16, 24, 32, 64};
  int off_tab [4] = '{1, 5, 10, 100};
  int pin_tab [7] = '{1, 2, 16, 8, 4, 12, 32};
  rseq_pin_model rseq_pin_model_i (.clk_in(clk_in), .ctl_set_in(ctl_set),
    .sleep_set_in(sleep_set), .pg_set_in(pg_set), .control_input_out(ctl),
    .sleep_input_out(sleep_input), .power_good_flag_out(pg));
  rseq_top #(.MS_CYCLES(MS)) rseq_top_i (.clk_in(clk_in), .srst_in(srst_in), .ce_in(ce),
    .reg_req_in(req), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
    .control_input_in(ctl), .sleep_input_in(sleep_input), .power_good_flag_in(pg),
    .aux_two_logic_en_in(a2), .aux_one_logic_en_in(a1), .switch_b_one_logic_en_in(b1),
    .switch_b_two_logic_en_in(b2), .step_down_six_step_25mv_in(s25),
    .aux_regulator_two_en_out(en2), .aux_regulator_three_en_out(en3),
    .aux_regulator_one_en_out(en1), .load_switch_b_two_en_out(enb2),
    .stepdown_six_pin_vsel_out(vsel), .stepdown_six_target_mv_out(mv));
  // ----------------------------------------------------------------------------
  // bus and timing tasks
  // ----------------------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in) req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_in) req <= '0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_in) req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_in) req <= '0;
    #1;
    `CHK(rvalid, 1'b1)
    `CHK(rdata, e)
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: return en2;
      1: return en3;
      2: return en1;
      default: return enb2;
    endcase
  endfunction
  // edges counted until the chosen enable reaches the level; bounded against hangs
  task automatic lat(input int s, input logic lv, output int k);
    k = 0;
    #1;
    while (pick(s) !== lv && k < 2000) begin
      @(posedge clk_in);
      #1;
      k++;
    end
    // a latency that never arrives is a failure, not just a wrong count
    if (k >= 2000) num_errors++;
  endtask
  task automatic finish_test;
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ----------------------------------------------------------------------------
  // clock, reset and watchdog
  // ----------------------------------------------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  initial begin
    #(60000 * 8);
    num_errors++;
    finish_test;
  end
  initial begin
    srst_in = 1'b1;
    ce = 1'b1;
    req = '0;
    ctl_set = '0;
    sleep_set = 1'b0;
    pg_set = '1;
    a1 = 1'b0;
    a2 = 1'b0;
    b1 = 1'b0;
    b2 = 1'b0;
    s25 = 1'b0;
    num_errors = 0;
    checked = 0;
    repeat (4) @(posedge clk_in);
    srst_in <= 1'b0;
    for (int a = 8'h1e; a <= 8'h22; a++) rd_chk(8'(a), 8'h00);
    for (int a = 8'h1e; a <= 8'h22; a++) wr(8'(a), 8'(8'ha5 + a));
    for (int a = 8'h1e; a <= 8'h21; a++)
      rd_chk(8'(a), 8'(8'ha5 + a) & (a == 8'h20 ? 8'h9f : 8'hff));
    rd_chk(8'h22, 8'h00);
    // a write while the clock enable is low must not be taken
    @(posedge clk_in) ce <= 1'b0;
    wr(8'h1f, 8'h5a);
    @(posedge clk_in) ce <= 1'b1;
    rd_chk(8'h1f, 8'hc4);
    wr(8'h1e, 8'h00);
    wr(8'h1f, 8'hff);
    wr(8'h21, 8'h00);
    // enable source select, one entry per code; 7 needs no pin at all
    for (int s = 0; s < 8; s++) begin
      wr(8'h20, 8'((s << 2) | 3));
      @(posedge clk_in) ctl_set <= (s == 7) ? 6'h00 : 6'(pin_tab[s % 7]);
      repeat (8) @(posedge clk_in);
      `CHK(en3, 1'b1)
      @(posedge clk_in) ctl_set <= 6'(~pin_tab[s % 7] | (pin_tab[s % 7] & (pin_tab[s % 7] - 1)));
      repeat (8) @(posedge clk_in);
      `CHK(en3, s == 7)
    end
    // each bad rail blocks the enable until its mask bit is set
    for (int k = 0; k < 10; k++) begin
      wr(8'h1f, 8'h00);
      wr(8'h20, 8'h1c);
      @(posedge clk_in) pg_set <= rseq_pg_t'(~(10'h1 << k));
      repeat (6) @(posedge clk_in);
      `CHK(en3, 1'b0)
      if (k < 8) wr(8'h1f, 8'(1 << k));
      else wr(8'h20, 8'(8'h1c | (1 << (k - 8))));
      repeat (6) @(posedge clk_in);
      `CHK(en3, 1'b1)
    end
    pg_set <= '1;
    // aux two rise then fall delays, measured against the no-delay latency
    for (int f = 0; f < 2; f++) begin
      for (int c = 0; c < 8; c++) begin
        wr(8'h1e, 8'(c << (3 * f)));
        @(posedge clk_in) a2 <= f[0];
        lat(0, f[0], n);
        @(posedge clk_in) a2 <= ~f[0];
        lat(0, ~f[0], n);
        if (c == 0) base = n;
        else `CHK(n - base, ms_tab[c] * MS)
      end
    end
    // aux three rise then fall delays, pin one as source
    wr(8'h20, 8'h03);
    for (int f = 0; f < 2; f++) begin
      for (int c = 0; c < 7; c += 6) begin
        wr(8'h21, 8'(c << (3 * f)));
        @(posedge clk_in) ctl_set <= 6'(f);
        lat(1, f[0], n);
        @(posedge clk_in) ctl_set <= 6'(1 - f);
        lat(1, ~f[0], n);
        if (c == 0) base = n;
        else `CHK(n - base, ms_tab[c] * MS)
      end
    end
    // shutdown off time of regulator one, logic back after one cycle
    wr(8'h21, 8'h00);
    for (int c = 0; c < 4; c++) begin
      wr(8'h1e, 8'(c << 6));
      @(posedge clk_in) a1 <= 1'b1;
      lat(2, 1'b1, n);
      @(posedge clk_in) a1 <= 1'b0;
      @(posedge clk_in) a1 <= 1'b1;
      lat(2, 1'b0, n);
      lat(2, 1'b1, n);
      if (c == 0) base = n;
      else `CHK(n - base, (off_tab[c] - 1) * MS)
    end
    // combine and swap routing, regulator one and switch b one logic high, switch b two low
    @(posedge clk_in) b1 <= 1'b1;
    for (int r = 0; r < 4; r++) begin
      wr(8'h21, 8'(r << 6));
      repeat (4) @(posedge clk_in);
      `CHK(en1, r[0] ? (r[1] ? 1'b1 : 1'b0) : 1'b1)
      `CHK(enb2, r[0] ? 1'b1 : r[1])
    end
    // step-down six pin voltage, option off then on, sleep overrides
    for (int o = 0; o < 2; o++) begin
      wr(8'h20, 8'(o << 7));
      @(posedge clk_in) ctl_set <= 6'h02;
      s25 <= o[0];
      repeat (5) @(posedge clk_in);
      `CHK(vsel, o[0])
      `CHK(mv, o[0] ? `RSEQ_SD6_MV_COARSE : `RSEQ_SD6_MV_FINE)
      @(posedge clk_in) sleep_set <= 1'b1;
      repeat (5) @(posedge clk_in);
      `CHK(vsel, 1'b0)
      sleep_set <= 1'b0;
    end
    finish_test;
  end
endmodule
`default_nettype wire
